// *** bench/tcx_src_model.sv ***
// Purpose: Far-side count sources, an external clock and a watch crystal.
// Assumes: Both are levels that change just after a clock edge.
// Notes: Each stands low while stopped, so no stale edge is seen.
`timescale 1ns/100ps
module tcx_src_model
(
    input wire logic clock_in,
    input wire logic run_in,
    input wire logic osc_on_in,
    output logic ext_clk_out = 1'b0,
    output logic xtal_clk_out = 1'b0
);
    int ph_q = 0; // Phase within a ten-cycle source period.
    always_ff @(posedge clock_in)
    begin
        ph_q <= (ph_q == 9) ? 0 : ph_q + 1;
        ext_clk_out <= run_in && !osc_on_in && ph_q < 5;
        xtal_clk_out <= run_in && osc_on_in && ph_q < 5;
    end
endmodule // tcx_src_model

// *** bench/tcx_timer_chk.sv ***
// Purpose: Port-level checks of the timer's bus answer and clock logic.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound to every instance of the timer top module.
`timescale 1ns/100ps
module tcx_timer_chk
    import tcx_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sleep_in,
    input wire logic crystal_osc_run_out,
    input wire logic [1:0] pin_dir_eff_out,
    input wire logic [1:0] pin_read_out,
    input wire logic [1:0] power_mode_out
);
    // Completed writes, decoded per register.
    wire acc_wr = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
    wire ctl_wr = acc_wr && paddr_in == TCX_OFS_CONTROL;
    wire osc_wr = ctl_wr && pwdata_in[TCX_BIT_OSCEN];
    wire sec_wr = acc_wr && paddr_in == TCX_OFS_SYSCLK && pwdata_in[1:0] == TCX_SCS_CRYSTAL;
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // Setup phase of a transfer.
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    // Answer in the access phase.
    sequence s_answer;
        pready_out && penable_in;
    endsequence
    property p_ready_next;
        s_setup |=> s_answer;
    endproperty
    property p_ready_acc;
        pready_out |-> psel_in && penable_in;
    endproperty
    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    property p_err_zero;
        pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
    endproperty
    property p_pins;
        crystal_osc_run_out && $past(crystal_osc_run_out) |-> pin_dir_eff_out == 2'h3 && pin_read_out == 2'h0;
    endproperty
    property p_osc_on;
        $rose(crystal_osc_run_out) |-> $past(osc_wr) || $past(osc_wr, 2);
    endproperty
    property p_osc_hold;
        $fell(crystal_osc_run_out) |-> $past(ctl_wr) || $past(ctl_wr, 2);
    endproperty
    property p_secondary_run;
        sec_wr && !sleep_in |-> ##[1:3] power_mode_out == TCX_PM_XRUN;
    endproperty
    property p_idle;
        power_mode_out == TCX_PM_XIDLE && $past(power_mode_out) == TCX_PM_XRUN
            |-> $past(sleep_in) || $past(sleep_in, 2);
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
    a_ready_acc: assert property (p_ready_acc) else $error("answer outside access");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    a_pins: assert property (p_pins) else $error("crystal pins not inputs");
    a_osc_on: assert property (p_osc_on) else $error("oscillator started alone");
    a_osc_hold: assert property (p_osc_hold) else $error("oscillator stopped alone");
    a_secondary_run: assert property (p_secondary_run) else $error("no secondary run");
    a_idle: assert property (p_idle) else $error("idle without sleep");
endmodule // tcx_timer_chk

bind tcx_timer tcx_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.clock_in(clock_in), .srst_in(srst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sleep_in(sleep_in),
    .crystal_osc_run_out(crystal_osc_run_out), .pin_dir_eff_out(pin_dir_eff_out),
    .pin_read_out(pin_read_out), .power_mode_out(power_mode_out));

// *** bench/tcx_timer_tb.sv ***
// Purpose: Self-checking bench driving the timer over its register bus.
// Assumes: Every transfer is answered; count sources come from the model.
// Notes: Prescaled counts of unknown phase are checked within one tick; the wrap count within 1..14.
`timescale 1ns/100ps
module tcx_timer_tb;
    import tcx_pkg::*;
    logic clock_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd_q;
    logic pready_out, pslverr_out, err_q, irq, osc_run, ext_clk, xtal_clk, src_q = 1'b0;
    logic src_run = 1'b0, sleep_in = 1'b0, mon_en = 1'b0, xfail = 1'b0;
    logic [1:0] pin_lvl = 2'h3, pin_dir = 2'h0, dir_eff, pin_rd, pmode;
    logic [7:0] srcs [3] = '{8'h03, 8'h07, 8'h0b};
    int error_cnt = 0, check_count = 0, rises = 0, cyc = 0;
    initial forever #25 clock_in = ~clock_in;
    tcx_timer u_dut (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(4'hf), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .ext_clk_in(ext_clk),
        .crystal_clk_in(xtal_clk), .sleep_in(sleep_in), .monitor_enable_in(mon_en),
        .crystal_fail_in(xfail), .pin_dir_in(pin_dir), .pin_level_in(pin_lvl),
        .overflow_irq_out(irq), .crystal_osc_run_out(osc_run), .pin_dir_eff_out(dir_eff),
        .pin_read_out(pin_rd), .power_mode_out(pmode));
    tcx_src_model u_src (.clock_in(clock_in), .run_in(src_run), .osc_on_in(osc_run),
        .ext_clk_out(ext_clk), .xtal_clk_out(xtal_clk));
    // Count rising edges of the watched source and cut a hang short.
    always @(posedge clock_in)
    begin
        src_q <= osc_run ? xtal_clk : ext_clk;
        if ((osc_run ? xtal_clk : ext_clk) && !src_q) rises <= rises + 1;
        cyc <= cyc + 1;
        if (cyc == 9000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // One transfer: idle edge, setup, access held until ready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1 && ++n < 20);
        rd_q = prdata_out;
        err_q = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) error_cnt++;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi, input logic [31:0] g);
        check_count++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %h", s, lo, hi, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input string s, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd_q);
    endtask
    // Main sequence of register tests.
    initial
    begin
        repeat (4) @(posedge clock_in);
        srst_in <= 1'b0;
        rc(TCX_OFS_CONTROL, "control", 32'h0);
        rc(8'h18, "unmapped", 32'h0);
        chk("slverr", 32'h1, err_q);
        chk("pin read", 32'h3, pin_rd);
        apb(1'b1, TCX_OFS_CONTROL, 32'h80);
        apb(1'b1, TCX_OFS_COUNT_HIGH, 32'h55);
        rc(TCX_OFS_COUNT_HIGH, "buffer", 32'h55);
        apb(1'b1, TCX_OFS_CONTROL, 32'h0);
        rc(TCX_OFS_COUNT_HIGH, "high", 32'h0);
        apb(1'b1, TCX_OFS_COUNT_HIGH, 32'h12);
        rc(TCX_OFS_COUNT_HIGH, "direct", 32'h12);
        apb(1'b1, TCX_OFS_CONTROL, 32'h80);
        apb(1'b1, TCX_OFS_COUNT_HIGH, 32'hff);
        apb(1'b1, TCX_OFS_COUNT_LOW, 32'hfe);
        rc(TCX_OFS_COUNT_LOW, "low", 32'hfe);
        rc(TCX_OFS_COUNT_HIGH, "snap", 32'hff);
        apb(1'b1, TCX_OFS_ENABLE, 32'h1);
        apb(1'b1, TCX_OFS_CONTROL, 32'h81);
        repeat (40) @(posedge clock_in);
        apb(1'b1, TCX_OFS_CONTROL, 32'h80);
        rc(TCX_OFS_FLAG, "flag", 32'h1);
        chk("irq", 32'h1, irq);
        apb(1'b0, TCX_OFS_COUNT_LOW, 32'h0);
        rng("wrap low", 1, 14, rd_q);
        rc(TCX_OFS_COUNT_HIGH, "wrap high", 32'h0);
        apb(1'b1, TCX_OFS_ENABLE, 32'h0);
        repeat (2) @(posedge clock_in);
        chk("masked", 32'h0, irq);
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, TCX_OFS_CONTROL, 32'h1 | (p << TCX_BIT_PS_LO));
            apb(1'b1, TCX_OFS_COUNT_LOW, 32'h0);
            repeat (320) @(posedge clock_in);
            apb(1'b0, TCX_OFS_COUNT_LOW, 32'h0);
            rng("prescale", 80 / (1 << p) - 1, 80 / (1 << p) + 1, rd_q);
        end
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, TCX_OFS_CONTROL, {24'h0, srcs[i]});
            repeat (20) @(posedge clock_in);
            chk("pin dir", srcs[i][3] ? 32'h3 : 32'h0, dir_eff);
            apb(1'b1, TCX_OFS_COUNT_LOW, 32'h0);
            rises = 0;
            src_run <= 1'b1;
            repeat (200) @(posedge clock_in);
            src_run <= 1'b0;
            repeat (10) @(posedge clock_in);
            rc(TCX_OFS_COUNT_LOW, "edges", rises);
        end
        apb(1'b1, TCX_OFS_SYSCLK, 32'h1);
        repeat (4) @(posedge clock_in);
        chk("mode", TCX_PM_XRUN, pmode);
        rc(TCX_OFS_CONTROL, "status", 32'h4b);
        sleep_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        chk("idle", TCX_PM_XIDLE, pmode);
        chk("osc", 32'h1, osc_run);
        sleep_in <= 1'b0;
        mon_en <= 1'b1;
        xfail <= 1'b1;
        repeat (4) @(posedge clock_in);
        rc(TCX_OFS_CONTROL, "failover", 32'h0b);
        apb(1'b1, TCX_OFS_CONTROL, 32'h0);
        repeat (3) @(posedge clock_in);
        chk("osc off", 32'h0, osc_run);
        conclude();
    end
endmodule // tcx_timer_tb

// *** pkg/tcx_pkg.sv ***
// Purpose: Shared constants for the sixteen-bit timer/counter block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets, field positions, reset values and timing counts live here.
package tcx_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets.
    // ----------------------------------------------------------------
    localparam logic [7:0] TCX_OFS_COUNT_LOW = 8'h00;
    localparam logic [7:0] TCX_OFS_COUNT_HIGH = 8'h04;
    localparam logic [7:0] TCX_OFS_CONTROL = 8'h08;
    localparam logic [7:0] TCX_OFS_FLAG = 8'h0c;
    localparam logic [7:0] TCX_OFS_ENABLE = 8'h10;
    localparam logic [7:0] TCX_OFS_SYSCLK = 8'h14;

    // ----------------------------------------------------------------
    // Control register field positions.
    // ----------------------------------------------------------------
    localparam int TCX_BIT_RUN = 0;
    localparam int TCX_BIT_SRC = 1;
    localparam int TCX_BIT_NOSYNC = 2;
    localparam int TCX_BIT_OSCEN = 3;
    localparam int TCX_BIT_PS_LO = 4;
    localparam int TCX_BIT_PS_HI = 5;
    localparam int TCX_BIT_STATUS = 6;
    localparam int TCX_BIT_WIDE = 7;

    // ----------------------------------------------------------------
    // System clock control register field positions.
    // ----------------------------------------------------------------
    localparam int TCX_BIT_SCS_LO = 0;
    localparam int TCX_BIT_SCS_HI = 1;
    localparam int TCX_BIT_IDLE = 7;

    // ----------------------------------------------------------------
    // Reset values and encodings.
    // ----------------------------------------------------------------
    localparam logic [7:0] TCX_CONTROL_RST = 8'h00;
    localparam logic [15:0] TCX_COUNT_RST = 16'h0000;
    localparam logic [15:0] TCX_COUNT_MAX = 16'hffff;
    localparam logic [1:0] TCX_SCS_CRYSTAL = 2'h1;
    localparam logic [1:0] TCX_CYCLE_DIV = 2'h3;

    // Power modes of the device as seen by this block.
    typedef enum logic [1:0] {
        TCX_PM_RUN = 2'b00,
        TCX_PM_XRUN = 2'b01,
        TCX_PM_XIDLE = 2'b10,
        TCX_PM_OTHER = 2'b11
    } tcx_pmode_t;

endpackage

// *** rtl/tcx_edge.sv ***
// Purpose: Rising-edge detector for the external count input.
// Assumes: Input is synchronous when bypassing the synchroniser.
// Notes: Synchronised path uses two flops, the first read only by the second.
`timescale 1ns/100ps
module tcx_edge
    import tcx_pkg::*;
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic ext_in,
    input wire logic bypass_in,
    output logic rise_out
);

    // ----------------------------------------------------------------
    // Synchroniser and edge history.
    // ----------------------------------------------------------------
    logic meta_q; // First synchroniser stage.
    logic sync_q; // Second synchroniser stage.
    logic prev_q; // Previous selected level.
    logic level;  // Level chosen by the bypass control.

    // Two-flop synchroniser chain.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= ext_in;
            sync_q <= meta_q;
        end
    end

    // Choose synchronised or raw level.
    always_comb
    begin
        level = bypass_in ? ext_in : sync_q;
    end

    // Remember the last level for edge detection.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= level;
        end
    end

    // A rising edge is a low-to-high step of the chosen level.
    always_comb
    begin
        rise_out = level & ~prev_q;
    end

endmodule // tcx_edge

// *** rtl/tcx_prescale.sv ***
// Purpose: Ratio prescaler of 1, 2, 4 or 8 for the timer count pulses.
// Assumes: Ticks are single-cycle pulses.
// Notes: A clear restarts the division from zero.
`timescale 1ns/100ps
module tcx_prescale
    import tcx_pkg::*;
#(
    parameter int PS_W = 3
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic clear_in,
    input wire logic tick_in,
    input wire logic [1:0] ratio_in,
    output logic pulse_out
);

    // ----------------------------------------------------------------
    // Division counter.
    // ----------------------------------------------------------------
    logic [PS_W-1:0] cnt_q; // Ticks counted so far.
    logic [PS_W-1:0] last;  // Count value that completes one period.

    // Last count for each ratio: 1:1, 1:2, 1:4, 1:8.
    always_comb
    begin
        case (ratio_in)
            2'h0: last = PS_W'(0);
            2'h1: last = PS_W'(1);
            2'h2: last = PS_W'(3);
            default: last = PS_W'(7);
        endcase
    end

    // Count ticks and wrap at the end of a period.
    always_ff @(posedge clock_in)
    begin
        if (srst_in || clear_in)
        begin
            cnt_q <= '0;
        end
        else if (tick_in)
        begin
            cnt_q <= (cnt_q >= last) ? '0 : cnt_q + PS_W'(1);
        end
    end

    // One output pulse per completed period.
    always_comb
    begin
        pulse_out = tick_in && !clear_in && (cnt_q >= last);
    end

endmodule // tcx_prescale

// *** rtl/tcx_timer.sv ***
// Purpose: Sixteen-bit timer/counter with APB registers and crystal control.
// Assumes: All inputs are synchronous to clock_in; APB answers with no wait.
// Notes: Oscillator pins are modelled as enable/direction levels only.
//
// Functional notes
// - Count pair counts up, wraps to zero.
// - Wrap sets overflow flag; enable gates request.
// - Count advances only while run bit set.
// - Source: cycle clock or external rising edge.
// - Sync bit zero synchronises external input.
// - Prescale select gives 1, 2, 4, 8.
// - Oscillator runs only while enable set.
// - Enabled oscillator forces pins input, read zero.
// - Status bit shows system clock from crystal.
// - Select code 01 enters secondary run.
// - Sleep in secondary run enters idle unless idle bit set.
// - Oscillator keeps running in power modes.
// - Monitor failover updates clock status bit.
// - Mode bit selects sixteen-bit or byte access.
// - Wide mode: low read copies high byte to buffer.
// - Wide mode: low write loads high from buffer.
// - Wide mode: high byte only via buffer.
// - Low writes clear prescaler; high writes don't.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
module tcx_timer
    import tcx_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic ext_clk_in,
    input wire logic crystal_clk_in,
    input wire logic sleep_in,
    input wire logic monitor_enable_in,
    input wire logic crystal_fail_in,
    input wire logic [1:0] pin_dir_in,
    input wire logic [1:0] pin_level_in,
    output logic overflow_irq_out,
    output logic crystal_osc_run_out,
    output logic [1:0] pin_dir_eff_out,
    output logic [1:0] pin_read_out,
    output logic [1:0] power_mode_out
);

    // ----------------------------------------------------------------
    // Register state.
    // ----------------------------------------------------------------
    logic [7:0] control_q;       // Writable control bits (status bit kept zero).
    logic [15:0] count_q;        // The counter pair.
    logic [7:0] high_buf_q;      // High byte buffer for wide access.
    logic overflow_flag_q;       // Sticky overflow flag.
    logic overflow_irq_enable_q; // Overflow request enable.
    logic [1:0] sysclk_select_q; // System clock select field.
    logic idle_on_sleep_q;       // Stay in secondary run rather than idle on sleep request.
    logic [1:0] cyc_q;           // Divider for the instruction cycle.
    logic status_q;              // System clock from crystal status.
    tcx_pmode_t pmode_q;         // Current power mode.

    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    logic access;     // Access phase of any transfer.
    logic wr;         // Write taking effect this edge.
    logic rd;         // Read taking effect this edge.
    logic hit_low;    // Address is the low count byte.
    logic hit_high;   // Address is the high count byte.
    logic hit_ctl;    // Address is the control register.
    logic hit_flag;   // Address is the flag register.
    logic hit_en;     // Address is the enable register.
    logic hit_sys;    // Address is the system clock register.
    logic mapped;     // Address is any known register.
    logic [7:0] wbyte; // Written byte.
    logic wide;       // Wide access mode active.

    always_comb
    begin
        access = psel_in && penable_in;
        hit_low = (paddr_in == ADDR_W'(TCX_OFS_COUNT_LOW));
        hit_high = (paddr_in == ADDR_W'(TCX_OFS_COUNT_HIGH));
        hit_ctl = (paddr_in == ADDR_W'(TCX_OFS_CONTROL));
        hit_flag = (paddr_in == ADDR_W'(TCX_OFS_FLAG));
        hit_en = (paddr_in == ADDR_W'(TCX_OFS_ENABLE));
        hit_sys = (paddr_in == ADDR_W'(TCX_OFS_SYSCLK));
        mapped = hit_low | hit_high | hit_ctl | hit_flag | hit_en | hit_sys;
        wr = access && pwrite_in && mapped && pstrb_in[0];
        rd = access && !pwrite_in && mapped;
        wbyte = pwdata_in[7:0];
        wide = control_q[TCX_BIT_WIDE];
    end

    // ----------------------------------------------------------------
    // Count source selection.
    // ----------------------------------------------------------------
    logic osc_en;    // Crystal oscillator enabled.
    logic ext_level; // External level: crystal or clock pin.
    logic ext_rise;  // Rising edge of the external source.
    logic cyc_tick;  // One pulse per instruction cycle.
    logic src_tick;  // Selected source pulse.
    logic ps_pulse;  // Prescaled pulse.
    logic ps_clear;  // Prescaler restart.
    logic inc;       // Counter increments this cycle.

    always_comb
    begin
        osc_en = control_q[TCX_BIT_OSCEN];
        ext_level = osc_en ? crystal_clk_in : ext_clk_in;
        cyc_tick = (cyc_q == TCX_CYCLE_DIV);
        src_tick = control_q[TCX_BIT_SRC] ? ext_rise : cyc_tick;
        ps_clear = wr && hit_low;
        inc = control_q[TCX_BIT_RUN] && ps_pulse;
    end

    // Instruction cycle divider: system clock over four.
    always_ff @(posedge clock_in)
    begin
        cyc_q <= srst_in ? 2'h0 : cyc_q + 2'h1;
    end

    tcx_edge u_edge (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .ext_in(ext_level),
        .bypass_in(control_q[TCX_BIT_NOSYNC]),
        .rise_out(ext_rise)
    );

    tcx_prescale #(.PS_W(3)) u_prescale (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .clear_in(ps_clear),
        .tick_in(src_tick),
        .ratio_in(control_q[TCX_BIT_PS_HI:TCX_BIT_PS_LO]),
        .pulse_out(ps_pulse)
    );

    // ----------------------------------------------------------------
    // Control registers.
    // ----------------------------------------------------------------
    // Control register write; the status bit is read-only.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            control_q <= TCX_CONTROL_RST;
        else if (wr && hit_ctl)
            control_q <= wbyte & ~(8'h01 << TCX_BIT_STATUS);
    end

    // System clock select and idle control.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            sysclk_select_q <= 2'h0;
            idle_on_sleep_q <= 1'b0;
        end
        else if (wr && hit_sys)
        begin
            sysclk_select_q <= wbyte[TCX_BIT_SCS_HI:TCX_BIT_SCS_LO];
            idle_on_sleep_q <= wbyte[TCX_BIT_IDLE];
        end
    end

    // Overflow request enable.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            overflow_irq_enable_q <= 1'b0;
        else if (wr && hit_en)
            overflow_irq_enable_q <= wbyte[0];
    end

    // ----------------------------------------------------------------
    // Counter and buffer.
    // ----------------------------------------------------------------
    // Counter: low writes, direct high writes in byte mode, increments.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            count_q <= TCX_COUNT_RST;
        end
        else if (wr && hit_low)
        begin
            count_q <= wide ? {high_buf_q, wbyte} : {count_q[15:8], wbyte};
        end
        else if (wr && hit_high && !wide)
        begin
            count_q <= {wbyte, count_q[7:0]};
        end
        else if (inc)
        begin
            count_q <= count_q + 16'h0001;
        end
    end

    // High byte buffer: in wide mode, written at high address, loaded on low reads.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            high_buf_q <= 8'h00;
        end
        else if (wide && rd && hit_low)
            high_buf_q <= count_q[15:8];
        else if (wide && wr && hit_high)
            high_buf_q <= wbyte;
    end

    // Overflow flag: set on wrap; set wins over a software clear.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            overflow_flag_q <= 1'b0;
        end
        else if (inc && count_q == TCX_COUNT_MAX && !(wr && (hit_low || (hit_high && !wide))))
        begin
            overflow_flag_q <= 1'b1;
        end
        else if (wr && hit_flag)
            overflow_flag_q <= wbyte[0];
    end

    // ----------------------------------------------------------------
    // Power mode and clock status.
    // ----------------------------------------------------------------
    // Power mode tracking from the select field and sleep request.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            pmode_q <= TCX_PM_RUN;
        end
        else
        begin
            case (pmode_q)
                TCX_PM_RUN, TCX_PM_OTHER:
                begin
                    pmode_q <= (sysclk_select_q == TCX_SCS_CRYSTAL) ? TCX_PM_XRUN : TCX_PM_RUN;
                end
                TCX_PM_XRUN:
                begin
                    if (sysclk_select_q != TCX_SCS_CRYSTAL)
                        pmode_q <= TCX_PM_RUN;
                    else if (sleep_in && !idle_on_sleep_q)
                        pmode_q <= TCX_PM_XIDLE;
                end
                TCX_PM_XIDLE:
                begin
                    if (!sleep_in)
                        pmode_q <= TCX_PM_XRUN;
                end
                default:
                begin
                    pmode_q <= TCX_PM_RUN;
                end
            endcase
        end
    end

    // Status bit: crystal supplies the clock, unless the monitor failed it.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            status_q <= 1'b0;
        end
        else
        begin
            status_q <= (pmode_q == TCX_PM_XRUN || pmode_q == TCX_PM_XIDLE)
                && !(monitor_enable_in && crystal_fail_in);
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs.
    // ----------------------------------------------------------------
    // Oscillator, pin and request outputs.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            overflow_irq_out <= 1'b0;
            crystal_osc_run_out <= 1'b0;
            pin_dir_eff_out <= 2'h3;
            pin_read_out <= 2'h0;
            power_mode_out <= 2'h0;
        end
        else
        begin
            overflow_irq_out <= overflow_flag_q && overflow_irq_enable_q;
            crystal_osc_run_out <= osc_en;
            pin_dir_eff_out <= osc_en ? 2'h3 : pin_dir_in;
            pin_read_out <= osc_en ? 2'h0 : pin_level_in;
            power_mode_out <= pmode_q;
        end
    end

    // APB answer: zero wait, error on unmapped addresses.
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
            prdata_out <= 32'h0000_0000;
            if (psel_in && !penable_in && !pwrite_in)
            begin
                if (hit_low)
                    prdata_out <= {24'h000000, count_q[7:0]};
                else if (hit_high)
                    prdata_out <= {24'h000000, wide ? high_buf_q : count_q[15:8]};
                else if (hit_ctl)
                    prdata_out <= {24'h000000, control_q[7], status_q, control_q[5:0]};
                else if (hit_flag)
                    prdata_out <= {31'h00000000, overflow_flag_q};
                else if (hit_en)
                    prdata_out <= {31'h00000000, overflow_irq_enable_q};
                else if (hit_sys)
                    prdata_out <= {24'h000000, idle_on_sleep_q, 5'h00, sysclk_select_q};
            end
        end
    end

endmodule // tcx_timer
